// [rtl/panel_defs.svh]
`ifndef PANEL_DEFS_SVH
`define PANEL_DEFS_SVH

`define CLK_MHZ          250
`define DEB_US           5
`define DEB_CYCLES       (`DEB_US * `CLK_MHZ)
`define BAL_DELAY_MS     1000
`define BAL_DELAY_CYC    (`BAL_DELAY_MS * 1000 * `CLK_MHZ)
`define IMB_BEEP_S       5
`define IMB_BEEP_CYC     (`IMB_BEEP_S * 1000000 * `CLK_MHZ)
`define RETRY_MIN        10
`define RETRY_CYC        (64'h1 * `RETRY_MIN * 60 * 1000000 * `CLK_MHZ)
`define FLASH_CYC        (250 * 1000 * `CLK_MHZ)
`define HOLD_CYCLES      4'h8
`define FILL_DEFAULT     3'h1
`define FILL_MAX         3'h4
`define NO_SIZE_FAULT    6'h09
`define DIAG_FAULT_LVL   3'h3
`define DIAG_SWITCH_LVL  3'h4
`define DIAG_LVL_MAX     3'h5
`define BEEPS_OPTION     3'h2
`define BEEPS_DIAG       3'h2
`define BEEPS_SIZE       3'h4
`define LED_BIT_SPIN     7
`define LED_BIT_12MIN    1
`define LED_BIT_6MIN     3
`define LED_BIT_RINSE1   5
`define LED_BIT_RINSE2   6

`endif

// [rtl/panel_pkg.sv]
package panel_pkg;
	typedef struct packed {
		logic power;
		logic start_pause;
		logic temp_up;
		logic temp_down;
		logic level_up;
		logic level_down;
		logic spin_up;
		logic spin_down;
		logic cycle_up;
		logic cycle_down;
		logic heavy_duty;
		logic regular;
		logic advance;
	} keys_t;

	typedef struct packed {
		logic [7:0] progress;
		logic [4:0] cycle;
		logic       heavy;
		logic       cold;
		logic       hot;
		logic       low_water;
		logic       med_water;
		logic       spin_hold;
		logic       spin_slow;
		logic       spin_med;
		logic       regular;
	} leds_t;

	typedef enum logic [1:0] {SIZE_NONE, SIZE_SMALL, SIZE_MEDIUM, SIZE_LARGE} size_t;
endpackage

// [rtl/service_panel.sv]
`timescale 1ns/10ps
`include "panel_defs.svh"

// Notes on behaviour
// [RL1] start/pause plus power enters option mode
// [RL2] cycle buttons pick five fill offsets
// [RL3] persistent imbalance stops, beeps every 5s
// [RL4] recovery enabled: refill and agitate, respin
// [RL5] recovery off by default, heavy-duty toggles
// [RL6] temp-down plus power enters diagnostics
// [RL7] level 3 shows last fault binary
// [RL8] spin LED excluded from fault display
// [RL9] fault shown for eight cycles after
// [RL10] level 4 mirrors lid on 12-minute LED
// [RL11] level 4 shows size on rinse/spin
// [RL12] balance lever lights 6-minute after 1s
// [RL13] regular button toggles pump, LED follows
// [RL14] temp keys drive cold and hot valves
// [RL15] auto-retry retries up to 10 minutes
// [RL16] auto-retry off reports faults at once
// [RL17] level-down toggles auto-retry, default on
// [RL18] retry off flashes five left LEDs
// [RL19] power off restores defaults, leaves diag
// [RL20] level-up toggles continuous repeat
// [RL21] repeat on flashes three right LEDs
// [RL22] temp-up plus power enters size mode
// [RL23] missing stored size raises fault nine
// [RL24] each press debounced, acted once
module service_panel
	import panel_pkg::*;
#(
	parameter int DEB_CYC   = `DEB_CYCLES,
	parameter int BAL_CYC   = `BAL_DELAY_CYC,
	parameter int BEEP_CYC  = `IMB_BEEP_CYC,
	// ten minutes of cycles does not fit in 32 bits
	parameter longint RETRY_CYC = `RETRY_CYC,
	parameter int FLASH_CYC = `FLASH_CYC
) (
	// clock and reset
	input  wire logic           clk,
	input  wire logic           reset_n,
	// keypad, raw levels
	input  wire panel_pkg::keys_t keys,
	// machine status
	input  wire logic           console_on,
	input  wire logic           lid_closed,
	input  wire logic           balance_lever,
	input  wire logic           imbalance,
	input  wire logic           fault_event,
	input  wire logic [5:0]     fault_code_in,
	input  wire logic           cycle_done,
	input  wire logic           download_bit,
	input  wire panel_pkg::size_t stored_size,
	// indicators and beeper
	output panel_pkg::leds_t    leds,
	output logic [2:0]          beep_count,
	output logic                beep_pulse,
	// actuators and settings
	output logic                pump_on,
	output logic                cold_valve,
	output logic                hot_valve,
	output logic                spin_stop,
	output logic                recover_fill,
	output logic                fault_report,
	output logic                repeat_cycle,
	output logic [2:0]          fill_offset,
	output panel_pkg::size_t    size_setting,
	output logic [5:0]          fault_shown
);
	import panel_pkg::*;

	typedef enum {M_OFF, M_NORMAL, M_OPTION, M_DIAG, M_SIZE} mode_t;

	localparam int NK = $bits(keys_t);

	// debounce, one stable level per key
	logic [NK-1:0] stable_reg, stable_next;
	logic [NK-1:0] press;
	logic [$clog2(DEB_CYC+1)-1:0] deb_reg [NK];
	logic [$clog2(DEB_CYC+1)-1:0] deb_next [NK];

	genvar g;
	generate
		for (g = 0; g < NK; g++) begin : g_deb
			always_comb begin
				deb_next[g] = deb_reg[g];
				stable_next[g] = stable_reg[g];
				if (keys[g] == stable_reg[g]) begin
					deb_next[g] = '0;
				end else if (deb_reg[g] == ($clog2(DEB_CYC+1))'(DEB_CYC - 1)) begin
					deb_next[g] = '0;
					stable_next[g] = keys[g]; // [RL24]
				end else begin
					deb_next[g] = deb_reg[g] + 1'b1;
				end
			end
			always_ff @(posedge clk) begin
				if (!reset_n) begin
					deb_reg[g] <= '0;
					stable_reg[g] <= 1'b0;
				end else begin
					deb_reg[g] <= deb_next[g];
					stable_reg[g] <= stable_next[g];
				end
			end
			// only the rising stable edge counts
			assign press[g] = stable_next[g] & ~stable_reg[g]; // [RL24]
		end
	endgenerate

	keys_t kp, kh;
	assign kp = keys_t'(press);
	assign kh = keys_t'(stable_reg);

	// mode and settings
	mode_t      mode_reg, mode_next;
	logic [2:0] lvl_reg, lvl_next;
	logic [2:0] fill_reg, fill_next;
	logic       recov_reg, recov_next;
	logic       retry_reg, retry_next;
	logic       rep_reg, rep_next;
	logic       pump_reg, pump_next;
	logic       cold_reg, cold_next;
	logic       hot_reg, hot_next;
	size_t      size_reg, size_next;
	logic [2:0] beeps_reg, beeps_next;
	logic       bp_reg, bp_next;

	always_comb begin
		mode_next = mode_reg;
		lvl_next = lvl_reg;
		fill_next = fill_reg;
		recov_next = recov_reg;
		retry_next = retry_reg;
		rep_next = rep_reg;
		pump_next = pump_reg;
		cold_next = cold_reg;
		hot_next = hot_reg;
		size_next = size_reg;
		beeps_next = beeps_reg;
		bp_next = 1'b0;
		unique case (mode_reg)
			M_OFF: begin
				if (kp.power) begin
					bp_next = 1'b1;
					if (kh.start_pause) begin
						mode_next = M_OPTION; // [RL1]
						beeps_next = `BEEPS_OPTION;
					end else if (kh.temp_down && !console_on) begin
						mode_next = M_DIAG; // [RL6]
						lvl_next = '0;
						beeps_next = `BEEPS_DIAG;
					end else if (kh.temp_up && !console_on) begin
						mode_next = M_SIZE; // [RL22]
						beeps_next = `BEEPS_SIZE;
					end else begin
						mode_next = M_NORMAL;
						bp_next = 1'b0;
					end
				end
			end
			M_NORMAL: begin
				if (kp.power) begin
					mode_next = M_OFF;
					retry_next = 1'b1; // [RL19]
					rep_next = 1'b0;
				end
			end
			M_OPTION: begin
				if (kp.power) begin
					mode_next = M_NORMAL; // [RL1]
				end else begin
					if (kp.cycle_up && fill_reg != `FILL_MAX) begin
						fill_next = fill_reg + 3'h1; // [RL2]
					end
					if (kp.cycle_down && fill_reg != 3'h0) begin
						fill_next = fill_reg - 3'h1; // [RL2]
					end
					if (kp.heavy_duty) begin
						recov_next = ~recov_reg; // [RL5]
					end
				end
			end
			M_DIAG: begin
				if (kp.power) begin
					mode_next = M_OFF; // [RL19]
					retry_next = 1'b1;
					rep_next = 1'b0;
					pump_next = 1'b0;
					cold_next = 1'b0;
					hot_next = 1'b0;
				end else begin
					if (kp.spin_up && lvl_reg != `DIAG_LVL_MAX) begin
						lvl_next = lvl_reg + 3'h1; // [RL7]
					end
					if (kp.spin_down && lvl_reg != 3'h0) begin
						lvl_next = lvl_reg - 3'h1;
					end
					if (kp.regular) begin
						pump_next = ~pump_reg; // [RL13]
					end
					if (kp.temp_down) begin
						cold_next = ~cold_reg; // [RL14]
					end
					if (kp.temp_up) begin
						hot_next = ~hot_reg; // [RL14]
					end
					if (kp.level_down) begin
						retry_next = ~retry_reg; // [RL17]
					end
					if (kp.level_up) begin
						rep_next = ~rep_reg; // [RL20]
					end
				end
			end
			M_SIZE: begin
				if (kp.power) begin
					mode_next = M_OFF;
				end else if (kp.temp_up) begin
					size_next = SIZE_SMALL; // [RL22]
				end else if (kp.level_up) begin
					size_next = SIZE_MEDIUM;
				end else if (kp.spin_up) begin
					size_next = SIZE_LARGE;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			mode_reg <= M_OFF;
			lvl_reg <= '0;
			fill_reg <= `FILL_DEFAULT;
			recov_reg <= 1'b0; // [RL5]
			retry_reg <= 1'b1; // [RL17]
			rep_reg <= 1'b0;
			pump_reg <= 1'b0;
			cold_reg <= 1'b0;
			hot_reg <= 1'b0;
			size_reg <= SIZE_NONE;
			beeps_reg <= '0;
			bp_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			lvl_reg <= lvl_next;
			fill_reg <= fill_next;
			recov_reg <= recov_next;
			retry_reg <= retry_next;
			rep_reg <= rep_next;
			pump_reg <= pump_next;
			cold_reg <= cold_next;
			hot_reg <= hot_next;
			size_reg <= size_next;
			beeps_reg <= beeps_next;
			bp_reg <= bp_next;
		end
	end

	// fault memory, balance delay, imbalance and retry timers
	logic [5:0] fcode_reg, fcode_next;
	logic [3:0] fage_reg, fage_next;
	logic [$clog2(BAL_CYC+1)-1:0]   bal_reg, bal_next;
	logic [$clog2(BEEP_CYC+1)-1:0]  ib_reg, ib_next;
	logic [$clog2(RETRY_CYC+1)-1:0] rt_reg, rt_next;
	logic [$clog2(FLASH_CYC+1)-1:0] fl_reg, fl_next;
	logic       blink_reg, blink_next;
	logic       imb_try_reg, imb_try_next;
	logic       stop_reg, stop_next;
	logic       recf_reg, recf_next;
	logic       rpt_reg, rpt_next;
	logic       ibeep;
	logic       size_missing;

	// unset stored size after part replacement counts as a fault
	assign size_missing = (stored_size == SIZE_NONE) && (size_reg == SIZE_NONE); // [RL23]

	always_comb begin
		fcode_next = fcode_reg;
		fage_next = fage_reg;
		if (cycle_done && fage_reg != `HOLD_CYCLES) begin
			fage_next = fage_reg + 4'h1; // [RL9]
		end
		if (fault_event) begin
			fcode_next = fault_code_in;
			fage_next = '0;
		end else if (size_missing && mode_reg == M_NORMAL) begin
			fcode_next = `NO_SIZE_FAULT; // [RL23]
			fage_next = '0;
		end
		bal_next = '0;
		if (balance_lever) begin
			bal_next = (bal_reg == ($clog2(BAL_CYC+1))'(BAL_CYC)) ? bal_reg : bal_reg + 1'b1;
		end
		fl_next = fl_reg + 1'b1;
		blink_next = blink_reg;
		if (fl_reg == ($clog2(FLASH_CYC+1))'(FLASH_CYC - 1)) begin
			fl_next = '0;
			blink_next = ~blink_reg;
		end
		// first imbalance retries the spin, a second one stops or recovers
		imb_try_next = imb_try_reg;
		stop_next = stop_reg;
		recf_next = 1'b0;
		ib_next = '0;
		ibeep = 1'b0;
		if (imbalance && !imb_try_reg) begin
			imb_try_next = 1'b1; // [RL3]
		end else if (imbalance && recov_reg) begin
			recf_next = 1'b1; // [RL4]
		end else if (imbalance) begin
			stop_next = 1'b1; // [RL3]
		end
		if (stop_reg) begin
			ib_next = ib_reg + 1'b1;
			if (ib_reg == ($clog2(BEEP_CYC+1))'(BEEP_CYC - 1)) begin
				ib_next = '0;
				ibeep = 1'b1; // [RL3]
			end
		end
		if (mode_reg != M_NORMAL) begin
			imb_try_next = 1'b0;
			stop_next = 1'b0;
		end
		// retry window when auto-retry is on, immediate otherwise
		rt_next = '0;
		rpt_next = 1'b0;
		if (fault_event || rt_reg != '0) begin
			if (!retry_reg) begin
				rpt_next = 1'b1; // [RL16]
			end else if (rt_reg == ($clog2(RETRY_CYC+1))'(RETRY_CYC)) begin
				rpt_next = 1'b1; // [RL15]
				rt_next = rt_reg;
			end else begin
				rt_next = rt_reg + 1'b1; // [RL15]
			end
		end
		if (mode_reg == M_OFF) begin
			rt_next = '0;
			rpt_next = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			fcode_reg <= '0;
			fage_reg <= `HOLD_CYCLES;
			bal_reg <= '0;
			ib_reg <= '0;
			rt_reg <= '0;
			fl_reg <= '0;
			blink_reg <= 1'b0;
			imb_try_reg <= 1'b0;
			stop_reg <= 1'b0;
			recf_reg <= 1'b0;
			rpt_reg <= 1'b0;
		end else begin
			fcode_reg <= fcode_next;
			fage_reg <= fage_next;
			bal_reg <= bal_next;
			ib_reg <= ib_next;
			rt_reg <= rt_next;
			fl_reg <= fl_next;
			blink_reg <= blink_next;
			imb_try_reg <= imb_try_next;
			stop_reg <= stop_next;
			recf_reg <= recf_next;
			rpt_reg <= rpt_next;
		end
	end

	// indicator composition, registered
	leds_t      led_next;
	logic [5:0] shown;

	assign shown = (fage_reg != `HOLD_CYCLES) ? fcode_reg : 6'h00; // [RL9]

	always_comb begin
		led_next = '0;
		unique case (mode_reg)
			M_OFF: begin
				led_next.progress[4:0] = {5{~retry_reg & blink_reg}}; // [RL18]
				led_next.progress[7:5] = rep_reg ? {3{blink_reg}} : 3'h7; // [RL21]
			end
			M_NORMAL: begin
				if (stop_reg) begin
					led_next.progress[`LED_BIT_RINSE2] = blink_reg; // [RL3]
				end
				led_next.progress[`LED_BIT_SPIN] = rpt_reg & blink_reg;
			end
			M_OPTION: begin
				led_next.cycle[fill_reg] = 1'b1; // [RL2]
				led_next.heavy = recov_reg; // [RL5]
			end
			M_DIAG: begin
				led_next.spin_hold = lvl_reg[0];
				led_next.spin_slow = lvl_reg[1];
				led_next.spin_med = lvl_reg[2];
				if (lvl_reg == `DIAG_FAULT_LVL) begin
					led_next.progress[5:0] = shown; // [RL7]
					led_next.progress[`LED_BIT_SPIN] = download_bit; // [RL8]
				end else if (lvl_reg == `DIAG_SWITCH_LVL) begin
					led_next.progress[`LED_BIT_12MIN] = lid_closed; // [RL10]
					led_next.progress[`LED_BIT_6MIN] =
						(bal_reg == ($clog2(BAL_CYC+1))'(BAL_CYC)); // [RL12]
					led_next.progress[`LED_BIT_RINSE1] = (size_setting == SIZE_SMALL); // [RL11]
					led_next.progress[`LED_BIT_RINSE2] = (size_setting == SIZE_MEDIUM);
					led_next.progress[`LED_BIT_SPIN] = (size_setting == SIZE_LARGE);
				end
				led_next.regular = pump_reg; // [RL13]
				led_next.cold = cold_reg; // [RL14]
				led_next.hot = hot_reg;
				led_next.low_water = retry_reg; // [RL17]
				led_next.med_water = rep_reg; // [RL20]
			end
			M_SIZE: begin
				led_next.cold = (size_reg == SIZE_SMALL); // [RL22]
				led_next.low_water = (size_reg == SIZE_MEDIUM);
				led_next.spin_hold = (size_reg == SIZE_LARGE);
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			leds <= '0;
			beep_count <= '0;
			beep_pulse <= 1'b0;
			pump_on <= 1'b0;
			cold_valve <= 1'b0;
			hot_valve <= 1'b0;
			spin_stop <= 1'b0;
			recover_fill <= 1'b0;
			fault_report <= 1'b0;
			repeat_cycle <= 1'b0;
			fill_offset <= `FILL_DEFAULT;
			size_setting <= SIZE_NONE;
			fault_shown <= '0;
		end else begin
			leds <= led_next;
			beep_count <= (bp_reg | ibeep) ? (ibeep ? `BEEPS_OPTION : beeps_reg) : beep_count;
			beep_pulse <= bp_reg | ibeep | rpt_reg; // continuous while reported
			pump_on <= pump_reg;
			cold_valve <= cold_reg;
			hot_valve <= hot_reg;
			spin_stop <= stop_reg;
			recover_fill <= recf_reg; // [RL4]
			fault_report <= rpt_reg;
			repeat_cycle <= rep_reg; // [RL20]
			fill_offset <= fill_reg;
			size_setting <= (size_reg != SIZE_NONE) ? size_reg : stored_size;
			fault_shown <= shown;
		end
	end
endmodule

// [sim/panel_checker_sva.sv]
`timescale 1ns/10ps
module panel_checker
	import panel_pkg::*;
(
	// clock and reset
	input wire logic             clk,
	input wire logic             reset_n,
	// watched inputs
	input wire panel_pkg::keys_t keys,
	input wire logic             imbalance,
	// watched outputs
	input wire panel_pkg::leds_t leds,
	input wire logic [2:0]       beep_count,
	input wire logic             beep_pulse,
	input wire logic             pump_on,
	input wire logic             cold_valve,
	input wire logic             hot_valve,
	input wire logic             spin_stop,
	input wire logic             recover_fill,
	input wire logic             fault_report,
	input wire logic [2:0]       fill_offset
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	AST_FILL_RANGE: assert property (fill_offset <= 3'h4)
		else $error("fill offset out of range");
	AST_FILL_STEP: assert property ((fill_offset != $past(fill_offset)) |->
		(fill_offset == $past(fill_offset) + 3'h1) || (fill_offset + 3'h1 == $past(fill_offset)))
		else $error("fill offset jumped");
	AST_CYCLE_LED: assert property ((leds.cycle != 5'h00) |-> leds.cycle == (5'h01 << fill_offset))
		else $error("cycle led does not match fill offset");
	AST_PUMP_LED: assert property (pump_on |-> leds.regular)
		else $error("pump runs with its led dark");
	AST_COLD_LED: assert property (cold_valve |-> leds.cold)
		else $error("cold valve open with its led dark");
	AST_HOT_LED: assert property (hot_valve |-> leds.hot)
		else $error("hot valve open with its led dark");
	AST_PUMP_CAUSE: assert property ($rose(pump_on) |-> $past(keys.regular) || $past(keys.regular, 2))
		else $error("pump started without a press");
	AST_BEEP_SINGLE: assert property (beep_pulse && !fault_report |=> !beep_pulse || fault_report)
		else $error("beep request longer than one cycle");
	AST_BEEP_COUNT: assert property (beep_pulse && !fault_report |-> beep_count inside {3'h2, 3'h4})
		else $error("unexpected beep count");
	AST_FAULT_BEEP: assert property (fault_report && $past(fault_report) |-> beep_pulse)
		else $error("fault reported without continuous beep");
	AST_STOP_CAUSE: assert property ($rose(spin_stop) |-> $past(imbalance) || $past(imbalance, 2))
		else $error("spin stop without imbalance");
	AST_RECOVER_NO_STOP: assert property (recover_fill |-> !spin_stop)
		else $error("recovery and stop together");
endmodule

bind service_panel panel_checker panel_checker_inst (.clk(clk), .reset_n(reset_n), .keys(keys),
	.imbalance(imbalance), .leds(leds), .beep_count(beep_count), .beep_pulse(beep_pulse),
	.pump_on(pump_on), .cold_valve(cold_valve), .hot_valve(hot_valve), .spin_stop(spin_stop),
	.recover_fill(recover_fill), .fault_report(fault_report), .fill_offset(fill_offset));

// [sim/keypad_person.sv]
`timescale 1ns/10ps
module keypad_person
	import panel_pkg::*;
(
	// clock
	input  wire logic       clk,
	// keypad levels
	output panel_pkg::keys_t keys
);
	initial keys = '0;

	// held well past debounce so each press gives one clean edge
	task automatic press(input int idx);
		@(posedge clk);
		#1 keys[idx] = 1'b1;
		repeat (8) @(posedge clk);
		#1 keys[idx] = 1'b0;
		repeat (8) @(posedge clk);
		// hand back off the edge so callers never race the design's registers
		#1;
	endtask

	// modifier goes down first and is held through the power press
	task automatic combo(input int mod);
		@(posedge clk);
		#1 keys[mod] = 1'b1;
		repeat (6) @(posedge clk);
		press(12);
		keys[mod] = 1'b0;
		repeat (8) @(posedge clk);
		#1;
	endtask

	// contact chatter shorter than the debounce time
	task automatic chatter(input int idx);
		@(posedge clk);
		#1 keys[idx] = 1'b1;
		@(posedge clk);
		#1 keys[idx] = 1'b0;
		repeat (8) @(posedge clk);
		#1;
	endtask
endmodule

// [sim/tb_service_panel.sv]
`timescale 1ns/10ps
module tb_service_panel;
	import panel_pkg::*;
	localparam int K_PWR = 12, K_START = 11, K_TUP = 10, K_TDN = 9, K_LUP = 8, K_LDN = 7;
	localparam int K_SUP = 6, K_SDN = 5, K_CUP = 4, K_CDN = 3, K_HEAVY = 2, K_REG = 1;
	logic        clk, reset_n, console_on, lid_closed, balance_lever, imbalance;
	logic        fault_event, cycle_done, download_bit, beep_pulse, pump_on, cold_valve;
	logic        hot_valve, spin_stop, recover_fill, fault_report, repeat_cycle, up;
	logic [5:0]  fault_code_in, fault_shown;
	logic [2:0]  beep_count, fill_offset, last_beeps, exp_fill;
	logic [4:0]  exp_diag;
	size_t       stored_size, size_setting;
	keys_t       keys;
	leds_t       leds;
	int          num_errors = 0, checked = 0, seed = 24, beeps = 0, fills = 0, i, k, n;
	int          dtab[5] = '{K_REG, K_TDN, K_TUP, K_LDN, K_LUP};
	int          stab[3] = '{K_TUP, K_LUP, K_SUP};

	initial clk = 1'b0;
	always #2 clk = ~clk;

	keypad_person keypad_person_inst (.clk(clk), .keys(keys));
	service_panel #(.DEB_CYC(2), .BAL_CYC(8), .BEEP_CYC(16), .RETRY_CYC(32), .FLASH_CYC(4))
		service_panel_inst (.clk(clk), .reset_n(reset_n), .keys(keys), .console_on(console_on),
		.lid_closed(lid_closed), .balance_lever(balance_lever), .imbalance(imbalance),
		.fault_event(fault_event), .fault_code_in(fault_code_in), .cycle_done(cycle_done),
		.download_bit(download_bit), .stored_size(stored_size), .leds(leds),
		.beep_count(beep_count), .beep_pulse(beep_pulse), .pump_on(pump_on),
		.cold_valve(cold_valve), .hot_valve(hot_valve), .spin_stop(spin_stop),
		.recover_fill(recover_fill), .fault_report(fault_report), .repeat_cycle(repeat_cycle),
		.fill_offset(fill_offset), .size_setting(size_setting), .fault_shown(fault_shown));

	always @(posedge clk) begin
		if (beep_pulse) begin
			beeps <= beeps + 1;
			last_beeps <= beep_count;
		end
		if (recover_fill)
			fills <= fills + 1;
	end

	function automatic logic [2:0] next_fill(input logic [2:0] cur, input logic go_up);
		if (go_up)
			return (cur == 3'h4) ? cur : cur + 3'h1;
		return (cur == 3'h0) ? cur : cur - 3'h1;
	endfunction

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int cnt);
		repeat (cnt) @(posedge clk);
		#1;
	endtask

	// bounded wait for a beep request after count n0
	task automatic wait_beep(input int n0);
		for (int j = 0; j < 60 && beeps == n0; j++)
			cyc(1);
		if (beeps == n0) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, beeps, n0 + 1);
			give_verdict();
		end
	endtask

	task automatic shake(input int cnt);
		imbalance = 1'b1;
		cyc(cnt);
	endtask

	initial begin
		reset_n = 1'b0;
		console_on = 1'b0;
		lid_closed = 1'b0;
		balance_lever = 1'b0;
		imbalance = 1'b0;
		fault_event = 1'b0;
		fault_code_in = 6'h00;
		cycle_done = 1'b0;
		download_bit = 1'b0;
		stored_size = SIZE_LARGE;
		repeat (4) @(posedge clk);
		#1 reset_n = 1'b1;
		cyc(8);
		check(fill_offset, 3'h1);
		check(size_setting, SIZE_LARGE);
		check(leds.progress, 8'hE0);
		$display("test reset done");

		n = beeps;
		keypad_person_inst.combo(K_START);
		wait_beep(n);
		check(last_beeps, 3'h2);
		check(leds.cycle, 5'h02);
		check(leds.heavy, 1'b0);
		exp_fill = 3'h1;
		for (i = 0; i < 16; i++) begin
			up = (i < 5) ? 1'b1 : (i < 11) ? 1'b0 : $random(seed);
			keypad_person_inst.press(up ? K_CUP : K_CDN);
			exp_fill = next_fill(exp_fill, up);
			check(fill_offset, exp_fill);
			check(leds.cycle, 5'h01 << exp_fill);
		end
		keypad_person_inst.press(K_HEAVY);
		check(leds.heavy, 1'b1);
		keypad_person_inst.press(K_PWR);
		shake(40);
		imbalance = 1'b0;
		cyc(4);
		check(fills > 0, 1'b1);
		check(spin_stop, 1'b0);
		// option entry is only honoured from the off state
		keypad_person_inst.press(K_PWR);
		keypad_person_inst.combo(K_START);
		check(leds.heavy, 1'b1);
		keypad_person_inst.press(K_HEAVY);
		check(leds.heavy, 1'b0);
		keypad_person_inst.press(K_PWR);
		n = beeps;
		shake(48);
		check(spin_stop, 1'b1);
		check(beeps - n >= 2, 1'b1);
		check(last_beeps, 3'h2);
		imbalance = 1'b0;
		keypad_person_inst.press(K_PWR);
		$display("test option and imbalance done");

		n = beeps;
		keypad_person_inst.combo(K_TUP);
		wait_beep(n);
		check(last_beeps, 3'h4);
		for (i = 0; i < 3; i++) begin
			keypad_person_inst.press(stab[i]);
			check(size_setting, i + 1);
			check({leds.cold, leds.low_water, leds.spin_hold}, 3'b100 >> i);
		end
		keypad_person_inst.press(K_PWR);
		$display("test size done");

		n = beeps;
		keypad_person_inst.combo(K_TDN);
		wait_beep(n);
		check(last_beeps, 3'h2);
		check({leds.low_water, leds.med_water}, 2'b10);
		download_bit = 1'b1;
		fault_code_in = 6'h31;
		fault_event = 1'b1;
		cyc(1);
		fault_event = 1'b0;
		cyc(16);
		check(fault_report, 1'b0);
		cyc(40);
		check(fault_report, 1'b1);
		for (i = 0; i < 9; i++)
			keypad_person_inst.press(i < 6 ? K_SDN : K_SUP);
		check({leds.spin_hold, leds.spin_slow, leds.spin_med}, 3'b110);
		check(leds.progress[5:0], 6'h31);
		check(leds.progress[7], 1'b1);
		download_bit = 1'b0;
		cyc(3);
		check(leds.progress, 8'h31);
		for (i = 0; i < 9; i++) begin
			cycle_done = 1'b1;
			cyc(1);
			cycle_done = 1'b0;
			cyc(2);
			if (i == 6)
				check(leds.progress[5:0], 6'h31);
		end
		check(leds.progress[5:0], 6'h00);
		keypad_person_inst.press(K_SUP);
		check({leds.spin_hold, leds.spin_slow, leds.spin_med}, 3'b001);
		check(leds.progress[7:5], 3'b100);
		lid_closed = 1'b1;
		cyc(3);
		check(leds.progress[1], 1'b1);
		lid_closed = 1'b0;
		balance_lever = 1'b1;
		cyc(3);
		check({leds.progress[1], leds.progress[3]}, 2'b00);
		cyc(12);
		check(leds.progress[3], 1'b1);
		balance_lever = 1'b0;
		keypad_person_inst.chatter(K_REG);
		check(pump_on, 1'b0);
		exp_diag = 5'b00010;
		for (i = 0; i < 14; i++) begin
			k = {$random(seed)} % 5;
			keypad_person_inst.press(dtab[k]);
			exp_diag[4 - k] = ~exp_diag[4 - k];
			check({pump_on, cold_valve, hot_valve, leds.low_water, repeat_cycle}, exp_diag);
			check({leds.regular, leds.cold, leds.hot, leds.med_water}, {exp_diag[4:2], exp_diag[0]});
		end
		keypad_person_inst.press(K_PWR);
		check({pump_on, cold_valve, hot_valve, repeat_cycle}, 4'h0);
		check(leds.progress, 8'hE0);
		$display("test diagnostic done");

		reset_n = 1'b0;
		stored_size = SIZE_NONE;
		cyc(4);
		reset_n = 1'b1;
		cyc(4);
		keypad_person_inst.combo(K_START);
		keypad_person_inst.press(K_PWR);
		cyc(4);
		check(fault_shown, 6'h09);
		$display("test missing size done");
		give_verdict();
	end
endmodule
